//--- core/rtdc_top.v
`timescale 1ns/10ps
`include "rtdc_defs.vh"

module rtdc_top #(
    parameter PRE_W = `RTDC_PRE_W
) (
    // Clock and power reset
    input wire core_clk,
    input wire resetn,
    // Count sources
    input wire int_src0,
    input wire int_src1,
    input wire ext_pin0,
    input wire ext_pin1,
    input wire [1:0] sel,
    // Prescaler control
    input wire div32_on,
    input wire div8_on,
    input wire run,
    // Reload values
    input wire [PRE_W-1:0] pre_reload,
    input wire [`RTDC_S0_W-1:0] s0_reload,
    input wire [`RTDC_S1_W-1:0] s1_reload,
    input wire [`RTDC_S2_W-1:0] s2_reload,
    input wire [`RTDC_S3_W-1:0] s3_reload,
    // Direct load of the time count
    input wire load,
    input wire [31:0] load_val,
    // Interrupt control
    input wire [4:0] irq_en,
    input wire alarm_en,
    input wire [31:0] alarm_time,
    // Time count read
    output reg [15:0] time_count_high,
    output reg [15:0] time_count_low,
    output reg [PRE_W-1:0] prescale_timer,
    // Interrupts
    output reg [5:0] irq_flags,
    output reg irq
);

    reg [1:0] ext0_sync_reg;
    reg [1:0] ext1_sync_reg;
    reg src_last_reg;
    reg [4:0] div32_reg;
    reg [2:0] div8_reg;
    reg [PRE_W-1:0] pre_reg;
    reg pre_ovf_reg;
    reg src_now;
    wire src_tick;
    wire t32;
    wire t8;
    wire [3:0] s_ovf;
    wire [31:0] cnt;
    wire [5:0] events;
    reg [1:0] sel_last_reg;
    reg [PRE_W-1:0] pre_view_reg;
    wire carry_s1;
    wire carry_s2;
    wire carry_s3;

    // External pins pass two flops; second flop used only
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ext0_sync_reg <= 2'h0;
            ext1_sync_reg <= 2'h0;
        end else begin
            ext0_sync_reg <= {ext0_sync_reg[0], ext_pin0};
            ext1_sync_reg <= {ext1_sync_reg[0], ext_pin1};
        end
    end

    always @* begin
        case (sel)
            `RTDC_SRC_INT0: src_now = int_src0;
            `RTDC_SRC_INT1: src_now = int_src1;
            `RTDC_SRC_EXT0: src_now = ext0_sync_reg[1];
            default: src_now = ext1_sync_reg[1];
        endcase
    end

    // Rising edge of the chosen source is one count enable; the cycle in which
    // sel moves is ignored, since old and new source levels could fake an edge
    assign src_tick = run & src_now & ~src_last_reg & (sel == sel_last_reg);

    assign t32 = div32_on ? (src_tick & (div32_reg == `RTDC_DIV32_LAST)) : src_tick;
    assign t8 = div8_on ? (t32 & (div8_reg == `RTDC_DIV8_LAST)) : t32;

    // only the power reset clears the chain
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            src_last_reg <= 1'b0;
            sel_last_reg <= `RTDC_SRC_INT0;
            div32_reg <= 5'h00;
            div8_reg <= 3'h0;
        end else begin
            src_last_reg <= src_now;
            sel_last_reg <= sel;
            if (src_tick && div32_on) begin
                div32_reg <= div32_reg + 5'h01;
            end
            if (t32 && div8_on) begin
                div8_reg <= div8_reg + 3'h1;
            end
        end
    end

    // prescale timer counts up and reloads
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pre_reg <= {PRE_W{`RTDC_PRE_RST}};
            pre_ovf_reg <= 1'b0;
        end else begin
            pre_ovf_reg <= 1'b0;
            if (t8) begin
                if (&pre_reg) begin
                    pre_reg <= pre_reload;
                    pre_ovf_reg <= 1'b1;
                end else begin
                    pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // four cascaded stages; carries are decoded from the counts so that every
    // stage steps on one edge and a read never catches a half-rippled time
    assign carry_s1 = pre_ovf_reg & (&cnt[`RTDC_S1_LSB-1:`RTDC_S0_LSB]);
    assign carry_s2 = carry_s1 & (&cnt[`RTDC_S2_LSB-1:`RTDC_S1_LSB]);
    assign carry_s3 = carry_s2 & (&cnt[`RTDC_S3_LSB-1:`RTDC_S2_LSB]);

    rtdc_stage #(.W(`RTDC_S0_W)) u_s0 (
        .core_clk(core_clk),
        .resetn(resetn),
        .count_en(pre_ovf_reg),
        .reload(s0_reload),
        .load(load),
        .load_val(load_val[`RTDC_S1_LSB-1:`RTDC_S0_LSB]),
        .count_reg(cnt[`RTDC_S1_LSB-1:`RTDC_S0_LSB]),
        .ovf_reg(s_ovf[0])
    );
    rtdc_stage #(.W(`RTDC_S1_W)) u_s1 (
        .core_clk(core_clk),
        .resetn(resetn),
        .count_en(carry_s1),
        .reload(s1_reload),
        .load(load),
        .load_val(load_val[`RTDC_S2_LSB-1:`RTDC_S1_LSB]),
        .count_reg(cnt[`RTDC_S2_LSB-1:`RTDC_S1_LSB]),
        .ovf_reg(s_ovf[1])
    );
    rtdc_stage #(.W(`RTDC_S2_W)) u_s2 (
        .core_clk(core_clk),
        .resetn(resetn),
        .count_en(carry_s2),
        .reload(s2_reload),
        .load(load),
        .load_val(load_val[`RTDC_S3_LSB-1:`RTDC_S2_LSB]),
        .count_reg(cnt[`RTDC_S3_LSB-1:`RTDC_S2_LSB]),
        .ovf_reg(s_ovf[2])
    );
    rtdc_stage #(.W(`RTDC_S3_W)) u_s3 (
        .core_clk(core_clk),
        .resetn(resetn),
        .count_en(carry_s3),
        .reload(s3_reload),
        .load(load),
        .load_val(load_val[31:`RTDC_S3_LSB]),
        .count_reg(cnt[31:`RTDC_S3_LSB]),
        .ovf_reg(s_ovf[3])
    );

    // overflow events gated by enables; alarm on match
    assign events = {alarm_en & (cnt == alarm_time),
                     irq_en & {s_ovf, pre_ovf_reg}};

    // halves and prescale timer read together as 48 bits
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            time_count_high <= 16'h0000;
            time_count_low <= 16'h0000;
            pre_view_reg <= {PRE_W{`RTDC_PRE_RST}};
            prescale_timer <= {PRE_W{`RTDC_PRE_RST}};
        end else begin
            time_count_high <= cnt[31:16];
            time_count_low <= cnt[15:0];
            // The timer reloads one edge before the stages step; the extra
            // flop keeps all 48 bits of one read from the same instant
            pre_view_reg <= pre_reg;
            prescale_timer <= pre_view_reg;
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq_flags <= 6'h00;
            irq <= 1'b0;
        end else begin
            // prescale timer and per-stage overflow pulses plus the alarm match; any one of them raises irq
            irq_flags <= events;
            irq <= |events;
        end
    end

endmodule

//--- core/rtdc_defs.vh
`ifndef RTDC_DEFS_VH
`define RTDC_DEFS_VH

// Clock source select codes
`define RTDC_SRC_INT0 2'h0
`define RTDC_SRC_INT1 2'h1
`define RTDC_SRC_EXT0 2'h2
`define RTDC_SRC_EXT1 2'h3

// Fixed prescaler ratios
`define RTDC_DIV32_LAST 5'h1f
`define RTDC_DIV8_LAST 3'h7

// Stage widths
`define RTDC_PRE_W 16
`define RTDC_S0_W 10
`define RTDC_S1_W 6
`define RTDC_S2_W 6
`define RTDC_S3_W 10

// Stage positions inside the 32-bit time count
`define RTDC_S0_LSB 0
`define RTDC_S1_LSB 10
`define RTDC_S2_LSB 16
`define RTDC_S3_LSB 22

// Reset values
// Prescale timer reset bit, spread over whatever width the timer has
`define RTDC_PRE_RST 1'h0
`define RTDC_CNT_RST 32'h0000_0000
`define RTDC_IEN_RST 5'h00

`endif

//--- core/rtdc_stage.v
`timescale 1ns/10ps
`include "rtdc_defs.vh"

module rtdc_stage #(
    parameter W = 10
) (
    // Clock and reset
    input wire core_clk,
    input wire resetn,
    // Control
    input wire count_en,
    input wire [W-1:0] reload,
    input wire load,
    input wire [W-1:0] load_val,
    // Status
    output reg [W-1:0] count_reg,
    output reg ovf_reg
);

    wire at_top;
    assign at_top = &count_reg;

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= {W{1'b0}};
            ovf_reg <= 1'b0;
        end else begin
            ovf_reg <= 1'b0;
            if (load) begin
                count_reg <= load_val;
            end else if (count_en) begin
                if (at_top) begin
                    count_reg <= reload;
                    ovf_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

//--- tb/rtdc_props.sv
`timescale 1ns/10ps
module rtdc_props (
    // Clock and reset
    input core_clk,
    input resetn,
    // Inputs
    input run,
    input load,
    input [31:0] load_val,
    input [9:0] s0_reload,
    input [4:0] irq_en,
    input alarm_en,
    // Outputs
    input [15:0] time_count_high,
    input [15:0] time_count_low,
    input [5:0] irq_flags,
    input irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire [31:0] cnt = {time_count_high, time_count_low};
    sequence idle4; (!run && !load) [*4]; endsequence
    sequence load2; load ##1 (load && $stable(load_val)); endsequence
    chk_reset_clear:
    assert property (disable iff (1'b0) !resetn ##1 !resetn |-> cnt == 32'h0000_0000
        && irq_flags == 6'h00 && !irq) else $error("bad reset");
    chk_irq_merge:
    assert property (irq == |irq_flags) else $error("bad merge");
    chk_gate_off:
    assert property (irq_en == 5'h00 && $past(irq_en) == 5'h00 && $past(irq_en, 2) == 5'h00
        |-> irq_flags[4:0] == 5'h00) else $error("bad gate");
    chk_alarm_off:
    assert property (!alarm_en && !$past(alarm_en) && !$past(alarm_en, 2) |-> !irq_flags[5])
        else $error("bad alarm");
    chk_flag_pulse:
    assert property (irq_flags[0] |=> !irq_flags[0]) else $error("bad pulse");
    chk_idle_hold:
    assert property (idle4 |=> $stable(cnt)) else $error("bad hold");
    chk_load_take:
    assert property (load2 |=> cnt == $past(load_val)) else $error("bad load");
    chk_s0_step:
    assert property ($changed(cnt[9:0]) && !load && !$past(load) && !$past(load, 2)
        |-> cnt[9:0] == $past(cnt[9:0]) + 10'h001 || cnt[9:0] == s0_reload)
        else $error("bad step");
endmodule
bind rtdc_top rtdc_props u_props (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(run),
    .load(load),
    .load_val(load_val),
    .s0_reload(s0_reload),
    .irq_en(irq_en),
    .alarm_en(alarm_en),
    .time_count_high(time_count_high),
    .time_count_low(time_count_low),
    .irq_flags(irq_flags),
    .irq(irq)
);

//--- tb/tb_rtdc_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_rtdc_top;
    logic core_clk = 1'b0, resetn = 1'b0, run = 1'b1, load = 1'b0, alarm_en = 1'b0;
    logic div32_on = 1'b0, div8_on = 1'b0;
    logic [1:0] sel = 2'h0, pre_reload = 2'h3;
    logic [3:0] src = 4'h0;
    logic [4:0] irq_en = 5'h00;
    logic [5:0] s1_reload = 6'h00, s2_reload = 6'h00;
    logic [9:0] s0_reload = 10'h000, s3_reload = 10'h000;
    logic [31:0] load_val = 32'h0000_0000, alarm_time = 32'h0000_0010;
    wire [15:0] time_count_high, time_count_low;
    wire [1:0] prescale_timer;
    wire [5:0] irq_flags;
    wire irq;
    wire [31:0] cnt = {time_count_high, time_count_low};
    int miscompares = 0, n_compared = 0, nirq = 0, k;
    int nflag[6], base[6];
    // Two-bit prescale timer: first overflow after four ticks, not 65536
    rtdc_top #(.PRE_W(2)) dut (
        .core_clk(core_clk),
        .resetn(resetn),
        .int_src0(src[0]),
        .int_src1(src[1]),
        .ext_pin0(src[2]),
        .ext_pin1(src[3]),
        .sel(sel),
        .div32_on(div32_on),
        .div8_on(div8_on),
        .run(run),
        .pre_reload(pre_reload),
        .s0_reload(s0_reload),
        .s1_reload(s1_reload),
        .s2_reload(s2_reload),
        .s3_reload(s3_reload),
        .load(load),
        .load_val(load_val),
        .irq_en(irq_en),
        .alarm_en(alarm_en),
        .alarm_time(alarm_time),
        .time_count_high(time_count_high),
        .time_count_low(time_count_low),
        .prescale_timer(prescale_timer),
        .irq_flags(irq_flags),
        .irq(irq)
    );
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (irq === 1'b1) nirq++;
        for (int i = 0; i < 6; i++) if (irq_flags[i] === 1'b1) nflag[i]++;
    end
    task step(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task tick(input int n);
        repeat (n) begin
            @(posedge core_clk) src[sel] <= 1'b1;
            @(posedge core_clk) src[sel] <= 1'b0;
        end
        // Covers the pin synchroniser and the stage pipeline
        step(8);
    endtask
    task ld(input [31:0] v);
        @(posedge core_clk) load <= 1'b1;
        load_val <= v;
        step(2);
        load <= 1'b0;
        step(3);
    endtask
    task t_src;
        for (int s = 0; s < 4; s++) begin
            @(posedge core_clk) sel <= s[1:0];
            ld(32'h0000_0000);
            tick(3);
            `CHK(cnt, 32'h0000_0003)
        end
        $display("sources ok");
    endtask
    task t_casc;
        @(posedge core_clk) s0_reload <= 10'h005;
        irq_en <= 5'h02;
        ld(32'h0000_03ff);
        k = nirq;
        base = nflag;
        tick(1);
        `CHK(cnt, 32'h0000_0405)
        `CHK(nirq - k, 1)
        `CHK(nflag[0] - base[0], 0)
        @(posedge core_clk) irq_en <= 5'h1f;
        ld(32'hffff_ffff);
        base = nflag;
        tick(1);
        `CHK(cnt, 32'h0000_0005)
        for (int i = 0; i < 5; i++) `CHK(nflag[i] - base[i], 1)
        @(posedge core_clk) irq_en <= 5'h00;
        $display("cascade ok");
    endtask
    task t_div;
        @(posedge core_clk) div8_on <= 1'b1;
        ld(32'h0000_0000);
        tick(8);
        `CHK(cnt, 32'h0000_0001)
        @(posedge core_clk) div8_on <= 1'b0;
        div32_on <= 1'b1;
        ld(32'h0000_0000);
        tick(32);
        `CHK(cnt, 32'h0000_0001)
        @(posedge core_clk) div32_on <= 1'b0;
        $display("dividers ok");
    endtask
    task t_hold;
        @(posedge core_clk) run <= 1'b0;
        ld(32'h0000_0009);
        tick(3);
        `CHK(cnt, 32'h0000_0009)
        @(posedge core_clk) run <= 1'b1;
        $display("hold ok");
    endtask
    task t_alarm;
        @(posedge core_clk) alarm_en <= 1'b1;
        ld(32'h0000_000f);
        `CHK(irq_flags[5], 1'b0)
        tick(1);
        `CHK(irq_flags[5], 1'b1)
        `CHK(irq, 1'b1)
        @(posedge core_clk) alarm_en <= 1'b0;
        step(4);
        `CHK(irq_flags[5], 1'b0)
        $display("alarm ok");
    endtask
    task finish_test;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        step(4);
        `CHK(cnt, 32'h0000_0000)
        resetn <= 1'b1;
        step(2);
        tick(4);
        `CHK({prescale_timer, cnt}, 34'h3_0000_0001)
        $display("warmup ok");
        t_src;
        t_casc;
        t_div;
        t_hold;
        t_alarm;
        finish_test;
    end
    // Run needs about 300 cycles; this allows over six times that
    initial begin
        #20000;
        miscompares++;
        finish_test;
    end
endmodule
